// File: rtl/csc_pkg.sv
/*
 * shared constants of the camera chip system control block: register map,
 * field positions, reset values and timing figures.
 * assumes a single 250 MHz system clock and a 32-bit AHB-Lite register port.
 */
package csc_pkg;
	// register byte offsets
	localparam logic [7:0] CSC_OFF_CTRL = 8'h00;
	localparam logic [7:0] CSC_OFF_STATUS = 8'h04;
	localparam logic [7:0] CSC_OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] CSC_OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] CSC_OFF_GPIO_OUT = 8'h10;
	localparam logic [7:0] CSC_OFF_GPIO_OE = 8'h14;
	localparam logic [7:0] CSC_OFF_GPIO_IN = 8'h18;
	localparam logic [7:0] CSC_OFF_MCU_ADDR = 8'h1c;
	localparam int CSC_OFF_W = 8;
	// control register fields
	localparam int CSC_CTRL_CAM_ON = 4;
	localparam int CSC_CTRL_USB_RST = 0;
	localparam logic CSC_CAM_ON_RST = 1'b0;
	// interrupt bits, same layout in status and mask
	localparam int CSC_IRQ_USB_RST = 0;
	localparam int CSC_IRQ_SUSPEND = 1;
	localparam int CSC_IRQ_RESUME = 2;
	localparam int CSC_IRQ_SNAP = 3;
	localparam int CSC_IRQ_W = 4;
	// strap bits latched from the memory data lines
	localparam int CSC_STRAP_W = 8;
	localparam int CSC_STRAP_FORCE_SUSP = 7;
	localparam int CSC_STRAP_SUSP_EN = 6;
	localparam int CSC_STRAP_PLL = 3;
	// status register fields
	localparam int CSC_ST_EEPROM = 8;
	localparam int CSC_ST_EXT_CTL = 9;
	localparam int CSC_ST_XCVR_INT = 10;
	localparam int CSC_ST_SUSPEND = 11;
	localparam int CSC_ST_PWR_DOWN = 12;
	localparam int CSC_ST_RST_OUT = 13;
	// clocks
	localparam longint CSC_CLK_SYS_HZ = 250_000_000;
	localparam longint CSC_CLK24_HZ = 24_000_000;
	localparam longint CSC_REF_PLL_OFF_HZ = 48_000_000;
	localparam longint CSC_REF_PLL_ON_HZ = 12_000_000;
	// least hold of the reset output after a usb reset command
	localparam longint CSC_USB_RST_HOLD_NS = 1000;
	localparam int CSC_USB_RST_HOLD_CYC =
		int'((CSC_USB_RST_HOLD_NS * CSC_CLK_SYS_HZ + 64'd999_999_999) / 64'd1_000_000_000);
	localparam int CSC_HOLD_W = $clog2(CSC_USB_RST_HOLD_CYC + 1);
	// ahb-lite encodings
	localparam logic [2:0] CSC_HSIZE_WORD = 3'h2;
	localparam logic [1:0] CSC_HRESP_OKAY = 2'h0;
endpackage

// File: rtl/csc_sync3.sv
/*
 * three-flop synchroniser for pins from outside the clock domain.
 * a bit of the output follows only once the second and third flops agree.
 * the chain has no reset so that straps can be sampled while reset holds.
 */
module csc_sync3
	import csc_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_q
);
	if (W < 1) begin
		$error("csc_sync3: width must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} csc_sync_type;

	csc_sync_type r_q, r_d;

	always_comb begin
		r_d = r_q;
		r_d.s1 = pin_in;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		// the first flop is only ever read by the second
		r_d.o = (~(r_q.s2 ^ r_q.s3) & r_q.s3) | ((r_q.s2 ^ r_q.s3) & r_q.o);
	end

	always_ff @(posedge clk_sys) begin
		r_q <= r_d;
	end

	assign sync_q = r_q.o;
endmodule

// File: rtl/csc_frac_div.sv
/*
 * fractional divider: makes a square wave of OUT_HZ from the system clock.
 * the period jitters by one system cycle since 250 is not a multiple of 48;
 * that is the price of having no second clock.
 */
module csc_frac_div
	import csc_pkg::*;
#(
	parameter longint IN_HZ = CSC_CLK_SYS_HZ,
	parameter longint OUT_HZ = CSC_CLK24_HZ
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	output logic clk_out_q
);
	localparam int ACC_W = 32;
	localparam logic [ACC_W-1:0] INC = ACC_W'(2 * OUT_HZ / 1_000_000);
	localparam logic [ACC_W-1:0] MOD = ACC_W'(IN_HZ / 1_000_000);

	// whole-MHz rates only; a slower output would leave the step at one or zero
	if (2 * OUT_HZ >= IN_HZ || OUT_HZ < 1_000_000) begin
		$error("csc_frac_div: output rate cannot be served");
	end

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic clk;
	} csc_div_type;

	csc_div_type r_q, r_d;

	always_comb begin
		r_d = r_q;
		if (r_q.acc + INC >= MOD) begin
			r_d.acc = r_q.acc + INC - MOD;
			r_d.clk = ~r_q.clk;
		end else begin
			r_d.acc = r_q.acc + INC;
		end
		if (sys_rst) begin
			r_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		r_q <= r_d;
	end

	assign clk_out_q = r_q.clk;
endmodule

// File: rtl/csc_sysctl.sv
/*
 * camera chip system control: reset output, suspend indicator, camera
 * power-down pair, strap capture, pin function selects, address latch of
 * the muxed controller bus, 24 MHz clock out and an AHB-Lite register port.
 * assumes: usb engine pulses usb_reset_cmd and holds usb_suspend on clk_sys;
 * all other pin inputs are asynchronous; the pad ring resolves *_oe_n.
 */
module csc_sysctl
	import csc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	input wire logic system_reset_input_n,
	input wire logic usb_reset_cmd,
	input wire logic usb_suspend,
	input wire logic external_controller_select,
	input wire logic internal_transceiver_select,
	input wire logic [7:0] upper_address_bus,
	input wire logic [7:0] muxed_addr_data_bus,
	input wire logic address_latch_strobe,
	input wire logic chip_select_snapshot_n,
	input wire logic serial_data_detect,
	input wire logic [7:0] memory_data_lines,
	output logic reset_output,
	output logic suspend_indicator,
	output logic power_down_low,
	output logic power_down_high,
	output logic clock_out_24,
	output logic pins_oe_n,
	output logic [7:0] general_io_out,
	output logic [7:0] general_io_oe_n,
	output logic [15:0] mcu_address,
	output logic mcu_chip_select_n,
	output logic usb_xcvr_internal,
	output logic pll_enable,
	output logic eeprom_present,
	output logic [7:0] config_straps,
	output logic irq
);
	localparam int SYNC_W = CSC_STRAP_W + 8 + 8 + 6;

	// refuse a package whose status layout overlaps or leaves the word
	if (CSC_STRAP_W > CSC_ST_EEPROM || CSC_ST_RST_OUT > 31) begin
		$error("csc_sysctl: status fields do not fit the word");
	end
	if (CSC_USB_RST_HOLD_CYC < 1) begin
		$error("csc_sysctl: usb reset hold must last at least one cycle");
	end

	typedef struct packed {
		logic [CSC_STRAP_W-1:0] strap;
		logic eeprom;
		logic force_pend;
		logic cam_on;
		logic [CSC_HOLD_W-1:0] hold;
		logic rst_out;
		logic susp;
		logic susp_in_prev;
		logic pd;
		logic [CSC_IRQ_W-1:0] irq_stat;
		logic [CSC_IRQ_W-1:0] irq_mask;
		logic irq;
		logic [7:0] gpio_out;
		logic [7:0] gpio_oe;
		logic ale_prev;
		logic snap_prev;
		logic [15:0] mcu_addr;
		logic cs_n;
		logic xcvr;
		logic ext;
		logic oe_n;
		logic [7:0] gpio_oe_n;
		logic wr_pend;
		logic [CSC_OFF_W-1:0] wr_addr;
		logic [31:0] rdata;
		logic rdy;
	} csc_state_type;

	csc_state_type r_q, r_d;

	logic [SYNC_W-1:0] pin_s;
	logic [7:0] md_s;
	logic [7:0] upper_s;
	logic [7:0] ad_s;
	logic ale_s;
	logic cs_snap_s;
	logic sdd_s;
	logic ext_s;
	logic xcvr_s;
	logic system_reset_input_n_s;
	logic clk24_q;

	logic [SYNC_W-1:0] pin_raw;

	assign pin_raw = {
		memory_data_lines,
		upper_address_bus,
		muxed_addr_data_bus,
		address_latch_strobe,
		chip_select_snapshot_n,
		serial_data_detect,
		external_controller_select,
		internal_transceiver_select,
		system_reset_input_n
	};

	csc_sync3 #(
		.W(SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.pin_in(pin_raw),
		.sync_q(pin_s)
	);

	assign {
		md_s,
		upper_s,
		ad_s,
		ale_s,
		cs_snap_s,
		sdd_s,
		ext_s,
		xcvr_s,
		system_reset_input_n_s
	} = pin_s;

	csc_frac_div #(
		.IN_HZ(CSC_CLK_SYS_HZ),
		.OUT_HZ(CSC_CLK24_HZ)
	) u_div (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_out_q(clk24_q)
	);

	logic addr_phase;
	logic hard_rst;
	logic usb_rst;
	logic any_rst;
	logic susp_rise;
	logic susp_fall;
	logic snap_ev;
	logic cam_wr_one;
	logic [CSC_IRQ_W-1:0] irq_ev;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	assign addr_phase = hsel && htrans[1] && hready;

	always_comb begin
		r_d = r_q;
		hard_rst = ~system_reset_input_n_s;
		usb_rst = usb_reset_cmd ||
			(r_q.wr_pend && r_q.wr_addr == CSC_OFF_CTRL && hwdata[CSC_CTRL_USB_RST]);
		any_rst = hard_rst || usb_rst || (r_q.hold != '0);
		cam_wr_one = r_q.wr_pend && r_q.wr_addr == CSC_OFF_CTRL && hwdata[CSC_CTRL_CAM_ON];
		susp_rise = usb_suspend && !r_q.susp_in_prev;
		susp_fall = !usb_suspend && r_q.susp_in_prev;
		snap_ev = !ext_s && !cs_snap_s && r_q.snap_prev;
		irq_ev = '0;
		status_word = '0;
		rd_word = '0;

		// register writes land in the data phase
		if (r_q.wr_pend) begin
			unique case (r_q.wr_addr)
				CSC_OFF_CTRL: r_d.cam_on = hwdata[CSC_CTRL_CAM_ON];
				CSC_OFF_IRQ_MASK: r_d.irq_mask = hwdata[CSC_IRQ_W-1:0];
				CSC_OFF_GPIO_OUT: r_d.gpio_out = hwdata[7:0];
				CSC_OFF_GPIO_OE: r_d.gpio_oe = hwdata[7:0];
				default: ;
			endcase
		end
		r_d.wr_pend = addr_phase && hwrite;
		r_d.wr_addr = haddr[CSC_OFF_W-1:0];

		if (usb_rst) begin
			r_d.hold = CSC_HOLD_W'(CSC_USB_RST_HOLD_CYC);
		end else if (r_q.hold != '0) begin
			r_d.hold = r_q.hold - 1'b1;
		end
		r_d.rst_out = hard_rst || usb_rst || (r_d.hold != '0);

		r_d.susp_in_prev = usb_suspend;
		if (any_rst) begin
			r_d.susp = 1'b0;
		end else if (susp_fall) begin
			r_d.susp = 1'b0;
		end else if ((susp_rise || r_q.force_pend) && r_q.strap[CSC_STRAP_SUSP_EN]) begin
			// force-suspend strap only counts when suspend is enabled
			r_d.susp = 1'b1;
		end
		r_d.force_pend = 1'b0;

		// latched power-down, a live cause beats the release
		if (any_rst || r_d.susp || !r_d.cam_on) begin
			r_d.pd = 1'b1;
		end else if (cam_wr_one) begin
			r_d.pd = 1'b0;
		end

		// address phase taken when the strobe falls
		r_d.ale_prev = ale_s;
		if (r_q.ale_prev && !ale_s) begin
			// upper byte only from pins acting as address
			r_d.mcu_addr = {ext_s ? upper_s : 8'h00, ad_s};
		end

		r_d.cs_n = ext_s ? cs_snap_s : 1'b1;
		r_d.snap_prev = cs_snap_s;
		r_d.ext = ext_s;
		r_d.xcvr = xcvr_s;

		// general io drive only in the no-controller mode
		r_d.gpio_oe_n = ext_s ? 8'hff : ~r_q.gpio_oe;
		r_d.oe_n = 1'b0;

		status_word[CSC_STRAP_W-1:0] = r_q.strap;
		status_word[CSC_ST_EEPROM] = r_q.eeprom;
		status_word[CSC_ST_EXT_CTL] = r_q.ext;
		status_word[CSC_ST_XCVR_INT] = r_q.xcvr;
		status_word[CSC_ST_SUSPEND] = r_q.susp;
		status_word[CSC_ST_PWR_DOWN] = r_q.pd;
		status_word[CSC_ST_RST_OUT] = r_q.rst_out;

		unique case (haddr[CSC_OFF_W-1:0])
			CSC_OFF_CTRL: rd_word[CSC_CTRL_CAM_ON] = r_q.cam_on;
			CSC_OFF_STATUS: rd_word = status_word;
			CSC_OFF_IRQ_STAT: rd_word[CSC_IRQ_W-1:0] = r_q.irq_stat;
			CSC_OFF_IRQ_MASK: rd_word[CSC_IRQ_W-1:0] = r_q.irq_mask;
			CSC_OFF_GPIO_OUT: rd_word[7:0] = r_q.gpio_out;
			CSC_OFF_GPIO_OE: rd_word[7:0] = r_q.gpio_oe;
			CSC_OFF_GPIO_IN: rd_word[7:0] = upper_s;
			CSC_OFF_MCU_ADDR: rd_word[15:0] = r_q.mcu_addr;
			default: rd_word = '0;
		endcase
		if (addr_phase && !hwrite) begin
			r_d.rdata = rd_word;
		end

		// sticky events; a read clears, a same-cycle event survives it
		irq_ev[CSC_IRQ_USB_RST] = usb_rst;
		irq_ev[CSC_IRQ_SUSPEND] = r_d.susp && !r_q.susp;
		irq_ev[CSC_IRQ_RESUME] = susp_fall && r_q.susp;
		irq_ev[CSC_IRQ_SNAP] = snap_ev;
		if (addr_phase && !hwrite && haddr[CSC_OFF_W-1:0] == CSC_OFF_IRQ_STAT) begin
			r_d.irq_stat = irq_ev;
		end else begin
			r_d.irq_stat = r_q.irq_stat | irq_ev;
		end
		r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
		r_d.rdy = 1'b1;

		if (sys_rst) begin
			// straps follow the data lines while reset holds
			r_d.strap = md_s;
			r_d.eeprom = sdd_s;
			// force-suspend is applied once, at the first edge out of reset
			r_d.force_pend = md_s[CSC_STRAP_FORCE_SUSP];
			r_d.cam_on = CSC_CAM_ON_RST;
			r_d.hold = '0;
			r_d.rst_out = 1'b1;
			r_d.susp = 1'b0;
			r_d.susp_in_prev = 1'b0;
			r_d.pd = 1'b1;
			r_d.irq_stat = '0;
			r_d.irq_mask = '0;
			r_d.irq = 1'b0;
			r_d.gpio_out = '0;
			r_d.gpio_oe = '0;
			r_d.ale_prev = 1'b0;
			r_d.snap_prev = 1'b1;
			r_d.mcu_addr = '0;
			r_d.cs_n = 1'b1;
			r_d.xcvr = 1'b0;
			r_d.ext = 1'b0;
			r_d.oe_n = 1'b1;
			r_d.gpio_oe_n = 8'hff;
			r_d.wr_pend = 1'b0;
			r_d.wr_addr = '0;
			r_d.rdata = '0;
			r_d.rdy = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		r_q <= r_d;
	end

	assign hrdata = r_q.rdata;
	assign hreadyout = r_q.rdy;
	assign hresp = CSC_HRESP_OKAY;
	assign reset_output = r_q.rst_out;
	assign suspend_indicator = r_q.susp;
	assign power_down_low = ~r_q.pd;
	assign power_down_high = r_q.pd;
	assign clock_out_24 = clk24_q;
	assign pins_oe_n = r_q.oe_n;
	assign general_io_out = r_q.gpio_out;
	assign general_io_oe_n = r_q.gpio_oe_n;
	assign mcu_address = r_q.mcu_addr;
	assign mcu_chip_select_n = r_q.cs_n;
	assign usb_xcvr_internal = r_q.xcvr;
	assign pll_enable = r_q.strap[CSC_STRAP_PLL];
	assign eeprom_present = r_q.eeprom;
	assign config_straps = r_q.strap;
	assign irq = r_q.irq;
endmodule

// File: verif/csc_usb_model.sv
/*
 * model of the usb engine beside the block: reset command pulses and the
 * suspend level. assumes it shares clk_sys with the block.
 */
module csc_usb_model (
	input wire logic clk_sys,
	output logic usb_reset_cmd,
	output logic usb_suspend
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		usb_reset_cmd = 1'b0;
		usb_suspend = 1'b0;
	end
	task bus_reset;
		@(posedge clk_sys);
		usb_reset_cmd <= 1'b1;
		@(posedge clk_sys);
		usb_reset_cmd <= 1'b0;
	endtask
	task set_suspend(input logic s);
		@(posedge clk_sys);
		usb_suspend <= s;
	endtask
endmodule

// File: verif/csc_sysctl_sva.sv
/*
 * checker of csc_sysctl: reset output, suspend, power-down pair, float
 * in reset and the 24 MHz clock. assumes it is bound to the top module.
 */
module csc_sysctl_chk
	import csc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic usb_reset_cmd,
	input wire logic usb_suspend,
	input wire logic [7:0] config_straps,
	input wire logic reset_output,
	input wire logic suspend_indicator,
	input wire logic power_down_low,
	input wire logic power_down_high,
	input wire logic pins_oe_n,
	input wire logic [7:0] general_io_oe_n,
	input wire logic clock_out_24
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// data phase of a control write, the only release of power-down
	logic wr_ctrl_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			wr_ctrl_q <= 1'b0;
		else
			wr_ctrl_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == CSC_OFF_CTRL;
	end
	sequence s_hold;
		reset_output [*8];
	endsequence
	sequence s_half;
		##[4:7] $fell(clock_out_24);
	endsequence
	property p_rst_cmd;
		usb_reset_cmd |=> s_hold;
	endproperty
	a_rst_cmd: assert property (p_rst_cmd) else $error("reset output not held");
	property p_susp_clr;
		usb_reset_cmd |=> ##[0:1] !suspend_indicator;
	endproperty
	a_susp_clr: assert property (p_susp_clr) else $error("suspend kept on reset");
	property p_susp_set;
		config_straps[CSC_STRAP_SUSP_EN] && !reset_output && !usb_reset_cmd && $rose(usb_suspend)
			|=> suspend_indicator;
	endproperty
	a_susp_set: assert property (p_susp_set) else $error("suspend not shown");
	property p_susp_fall;
		$fell(usb_suspend) |=> !suspend_indicator;
	endproperty
	a_susp_fall: assert property (p_susp_fall) else $error("suspend kept on resume");
	property p_pd_cmd;
		usb_reset_cmd |=> ##[0:1] !power_down_low;
	endproperty
	a_pd_cmd: assert property (p_pd_cmd) else $error("no power-down on reset");
	property p_pd_pair;
		suspend_indicator || reset_output |-> power_down_high && !power_down_low;
	endproperty
	a_pd_pair: assert property (p_pd_pair) else $error("power-down pair disagree");
	property p_pd_latch;
		power_down_high && !wr_ctrl_q |=> power_down_high;
	endproperty
	a_pd_latch: assert property (p_pd_latch) else $error("power-down released");
	property p_float;
		disable iff (1'b0)
		sys_rst |=> pins_oe_n && general_io_oe_n == 8'hff && reset_output && power_down_high;
	endproperty
	a_float: assert property (p_float) else $error("pins driven in reset");
	property p_clk24;
		$rose(clock_out_24) |-> s_half;
	endproperty
	a_clk24: assert property (p_clk24) else $error("clock out half period");
	c_susp: cover property (suspend_indicator);
endmodule

bind csc_sysctl csc_sysctl_chk chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.usb_reset_cmd(usb_reset_cmd), .usb_suspend(usb_suspend), .config_straps(config_straps),
	.reset_output(reset_output), .suspend_indicator(suspend_indicator),
	.power_down_low(power_down_low), .power_down_high(power_down_high),
	.pins_oe_n(pins_oe_n), .general_io_oe_n(general_io_oe_n), .clock_out_24(clock_out_24));

// File: verif/tb.sv
/*
 * testbench of csc_sysctl: ahb-lite register tasks and pin scenarios.
 * assumes the usb engine model and the bound checker.
 */
module tb
	import csc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, system_reset_input_n;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic usb_reset_cmd, usb_suspend, external_controller_select, internal_transceiver_select;
	logic [7:0] upper_address_bus, muxed_addr_data_bus, memory_data_lines, general_io_out;
	logic [7:0] general_io_oe_n, config_straps;
	logic address_latch_strobe, chip_select_snapshot_n, serial_data_detect, reset_output;
	logic suspend_indicator, power_down_low, power_down_high, clock_out_24, pins_oe_n;
	logic [15:0] mcu_address;
	logic mcu_chip_select_n, usb_xcvr_internal, pll_enable, eeprom_present, irq, p24;
	int miscompares, check_count, n, c24;
	assign hready = hreadyout;
	csc_sysctl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.system_reset_input_n(system_reset_input_n), .usb_reset_cmd(usb_reset_cmd),
		.usb_suspend(usb_suspend), .external_controller_select(external_controller_select),
		.internal_transceiver_select(internal_transceiver_select),
		.upper_address_bus(upper_address_bus), .muxed_addr_data_bus(muxed_addr_data_bus),
		.address_latch_strobe(address_latch_strobe),
		.chip_select_snapshot_n(chip_select_snapshot_n),
		.serial_data_detect(serial_data_detect), .memory_data_lines(memory_data_lines),
		.reset_output(reset_output), .suspend_indicator(suspend_indicator),
		.power_down_low(power_down_low), .power_down_high(power_down_high),
		.clock_out_24(clock_out_24), .pins_oe_n(pins_oe_n),
		.general_io_out(general_io_out), .general_io_oe_n(general_io_oe_n),
		.mcu_address(mcu_address), .mcu_chip_select_n(mcu_chip_select_n),
		.usb_xcvr_internal(usb_xcvr_internal), .pll_enable(pll_enable),
		.eeprom_present(eeprom_present), .config_straps(config_straps), .irq(irq));
	csc_usb_model host (.clk_sys(clk_sys), .usb_reset_cmd(usb_reset_cmd),
		.usb_suspend(usb_suspend));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task ack;
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			final_report;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		ack;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		ack;
		rv = hrdata;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task strap_reset(input logic [7:0] md, input logic sd);
		sys_rst <= 1'b1;
		memory_data_lines <= md;
		serial_data_detect <= sd;
		cyc(4);
		chk(pins_oe_n, 1);
		cyc(1);
		sys_rst <= 1'b0;
		cyc(4);
		chk(config_straps, md);
		chk(eeprom_present, sd);
		chk(pll_enable, md[3]);
		chk(pins_oe_n, 0);
		$display("test straps %h done", md);
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		final_report;
	end
	initial begin
		miscompares = 0;
		check_count = 0;
		{sys_rst, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = CSC_HSIZE_WORD;
		system_reset_input_n = 1'b1;
		{external_controller_select, internal_transceiver_select} = 2'b01;
		upper_address_bus = 8'h3c;
		{muxed_addr_data_bus, address_latch_strobe, chip_select_snapshot_n} = 10'h1;
		strap_reset(8'h48, 1'b1);
		chk(usb_xcvr_internal, 1);
		chk(power_down_high, 1);
		xfer(0, CSC_OFF_CTRL, 0);
		chk(rv, 0);
		xfer(0, 8'h40, 0);
		chk(rv, 0);
		xfer(1, CSC_OFF_IRQ_MASK, 32'hf);
		xfer(0, CSC_OFF_IRQ_MASK, 0);
		chk(rv, 32'hf);
		xfer(1, CSC_OFF_CTRL, 32'h10);
		cyc(1);
		chk(power_down_low, 1);
		host.set_suspend(1);
		cyc(2);
		chk(suspend_indicator, 1);
		chk(power_down_low, 0);
		host.set_suspend(0);
		cyc(4);
		chk(suspend_indicator, 0);
		chk(power_down_low, 0);
		chk(irq, 1);
		xfer(0, CSC_OFF_IRQ_STAT, 0);
		chk(rv, 32'h6);
		cyc(3);
		chk(irq, 0);
		xfer(1, CSC_OFF_CTRL, 32'h10);
		cyc(1);
		chk(power_down_high, 0);
		$display("test suspend done");
		host.bus_reset;
		cyc(2);
		chk(reset_output, 1);
		chk(power_down_high, 1);
		cyc(248);
		chk(reset_output, 1);
		cyc(1);
		chk(reset_output, 0);
		xfer(0, CSC_OFF_IRQ_STAT, 0);
		chk(rv, 32'h1);
		system_reset_input_n <= 1'b0;
		cyc(8);
		chk(reset_output, 1);
		system_reset_input_n <= 1'b1;
		for (n = 0; n < 400 && reset_output !== 1'b0; n++) cyc(1);
		chk(reset_output, 0);
		$display("test resets done");
		xfer(1, CSC_OFF_GPIO_OE, 32'hff);
		xfer(1, CSC_OFF_GPIO_OUT, 32'ha5);
		cyc(1);
		chk(general_io_out, 8'ha5);
		chk(general_io_oe_n, 8'h00);
		xfer(0, CSC_OFF_GPIO_IN, 0);
		chk(rv, 32'h3c);
		chk_sel;
		xfer(0, CSC_OFF_MCU_ADDR, 0);
		chk(rv, 32'h1234);
		$display("test pins done");
		p24 = clock_out_24;
		c24 = 0;
		for (n = 0; n < 1042; n++) begin
			@(posedge clk_sys);
			c24 += int'(clock_out_24 === 1'b1 && p24 === 1'b0);
			p24 = clock_out_24;
		end
		chk(c24 >= 99 && c24 <= 101, 1);
		strap_reset(8'hc0, 1'b0);
		chk(suspend_indicator, 1);
		xfer(0, CSC_OFF_STATUS, 0);
		chk(rv, 32'h1ac0);
		chk(hresp, CSC_HRESP_OKAY);
		xfer(1, CSC_OFF_CTRL, 32'h1);
		cyc(1);
		chk(reset_output, 1);
		chk(suspend_indicator, 0);
		$display("test software reset done");
		final_report;
	end
	task chk_sel;
		chip_select_snapshot_n <= 1'b0;
		cyc(8);
		xfer(0, CSC_OFF_IRQ_STAT, 0);
		chk(rv, 32'h8);
		chip_select_snapshot_n <= 1'b1;
		external_controller_select <= 1'b1;
		internal_transceiver_select <= 1'b0;
		{upper_address_bus, muxed_addr_data_bus} <= 16'h1234;
		cyc(1);
		address_latch_strobe <= 1'b1;
		cyc(4);
		address_latch_strobe <= 1'b0;
		cyc(10);
		chk(mcu_address, 16'h1234);
		chk(general_io_oe_n, 8'hff);
		chk(usb_xcvr_internal, 0);
		chip_select_snapshot_n <= 1'b0;
		cyc(8);
		chk(mcu_chip_select_n, 0);
		chip_select_snapshot_n <= 1'b1;
	endtask
endmodule
